//--- amrs_map.vh
// Purpose: Register offsets, field positions and timing constants of the read sequencer
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   Included by the sequencer top and by the bench
`ifndef AMRS_MAP_VH
`define AMRS_MAP_VH

// Register byte offsets
`define AMRS_OFF_CTRL     8'h00
`define AMRS_OFF_TIMING   8'h04
`define AMRS_OFF_ADDR     8'h08
`define AMRS_OFF_SELECT   8'h0c
`define AMRS_OFF_STATUS   8'h10
`define AMRS_OFF_RDATA    8'h14

// Control fields
`define AMRS_CTRL_RDYEN   0
`define AMRS_CTRL_CKSEL_LO 4
`define AMRS_CTRL_CKSEL_HI 5
`define AMRS_CKSEL_SYSCLK 2'h3

// Timing fields, six bits each
`define AMRS_FW           6
`define AMRS_TIM_PRESETUP 0
`define AMRS_TIM_SETUP    6
`define AMRS_TIM_PREACC   12
`define AMRS_TIM_ACCESS   18
`define AMRS_TIM_HOLD     24
`define AMRS_TIM_RESET    32'h01041041

// Select fields
`define AMRS_SEL_BANK_LO  0
`define AMRS_SEL_BE_LO    8

// Status bits
`define AMRS_STAT_BUSY    0
`define AMRS_STAT_DONE    1

// Ready-to-strobe delay: edges counted after ready is seen
`define AMRS_RDY_DELAY    2'h2

`endif

//--- amrs_top.v
// Purpose: Read-cycle sequencer for an asynchronous static memory, APB programmed
// Assumes: Pins and external_ready are synchronous to clk_sys (100 MHz)
// Notes:   A phase count of zero is treated as one cycle
`timescale 1ns/1ps
`default_nettype none
`include "amrs_map.vh"

// Overview of operation
// RULE1 - Bank select and address are driven for pre-setup plus setup plus pre-access cycles before the strobe falls.
// RULE2 - Output enable goes active after pre-setup, setup plus pre-access cycles before the strobe falls.
// RULE3 - With ready sensing off the strobe stays low for exactly the access count.
// RULE4 - Address, bank select, output enable and byte enables stay stable for the hold count after the strobe rises.
// RULE5 - With ready sensing on the strobe rises 2.5 to 3.5 cycles after ready is seen asserted.
// RULE6 - With ready sensing on the memory presents a valid ready no later than access minus 2.5 cycles after the fall.
// RULE7 - With clock output select at 3 the clock pin carries a buffered copy of the system clock.
// RULE8 - Each read runs pre-setup, setup, pre-access, access and hold in order, each timed by a loaded counter.
module amrs_top #(
  parameter AW = 24,
  parameter DW = 16,
  parameter NB = 4,
  parameter BW = 2
) (
  input  wire          clk_sys,
  input  wire          rst,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  output reg  [NB-1:0] bank_select_n,
  output reg  [AW-1:0] mem_address,
  output reg           output_enable_n,
  output reg           read_strobe_n,
  output reg  [BW-1:0] byte_enable_n,
  input  wire [DW-1:0] mem_data_in,
  input  wire          external_ready,
  output wire          clock_output_pin
);

  localparam [2:0] ST_IDLE     = 3'h0;
  localparam [2:0] ST_PRESETUP = 3'h1;
  localparam [2:0] ST_SETUP    = 3'h2;
  localparam [2:0] ST_PREACC   = 3'h3;
  localparam [2:0] ST_ACCESS   = 3'h4;
  localparam [2:0] ST_HOLD     = 3'h5;

  reg [31:0]           ctrl_reg;
  reg [31:0]           timing_reg;
  reg [AW-1:0]         addr_reg;
  reg [NB-1:0]         bank_reg;
  reg [BW-1:0]         be_reg;
  reg [DW-1:0]         rdata_reg;
  reg                  done_reg;
  reg [2:0]            state_reg;
  reg [2:0]            state_next;
  reg [`AMRS_FW-1:0]   cnt_reg;
  reg [`AMRS_FW-1:0]   cnt_next;
  reg                  rdy_seen_reg;
  reg [1:0]            rdy_cnt_reg;
  reg                  rdy_end;
  wire                 rdy_en;
  wire                 acc_done;
  wire                 wr_take;
  wire                 rd_take;
  wire                 start;

  // Phase length from a timing field, zero stretched to one cycle
  function [`AMRS_FW-1:0] phase_len;
    input [31:0]  tim;
    input integer lo;
    reg   [`AMRS_FW-1:0] f;
    begin
      f = tim[lo +: `AMRS_FW];
      phase_len = (f == {`AMRS_FW{1'b0}}) ? {{(`AMRS_FW-1){1'b0}}, 1'b1} : f;
    end
  endfunction

  assign rdy_en  = ctrl_reg[`AMRS_CTRL_RDYEN];
  assign wr_take = psel & penable & pready & pwrite;
  assign rd_take = psel & penable & pready & ~pwrite;
  // Writing the address register launches a read; ignored while busy
  assign start   = wr_take & (paddr == `AMRS_OFF_ADDR) & (state_reg == ST_IDLE);
  assign acc_done = (cnt_reg == {{(`AMRS_FW-1){1'b0}}, 1'b1});

  // Buffered copy of the sequencer clock; gating keeps it quiet otherwise
  assign clock_output_pin = clk_sys & (ctrl_reg[`AMRS_CTRL_CKSEL_HI:`AMRS_CTRL_CKSEL_LO] == `AMRS_CKSEL_SYSCLK); // RULE7

  // Ready path ends the access a fixed number of edges after ready is seen
  always @* begin
    rdy_end = rdy_seen_reg & (rdy_cnt_reg == 2'h0); // RULE5
  end

  // Phase sequencing with a counter reloaded on each phase entry
  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_PRESETUP; // RULE8
          cnt_next   = phase_len(timing_reg, `AMRS_TIM_PRESETUP);
        end
      end
      ST_PRESETUP: begin
        if (acc_done) begin
          state_next = ST_SETUP; // RULE2
          cnt_next   = phase_len(timing_reg, `AMRS_TIM_SETUP);
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ST_SETUP: begin
        if (acc_done) begin
          state_next = ST_PREACC;
          cnt_next   = phase_len(timing_reg, `AMRS_TIM_PREACC);
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ST_PREACC: begin
        if (acc_done) begin
          state_next = ST_ACCESS; // RULE1
          cnt_next   = phase_len(timing_reg, `AMRS_TIM_ACCESS);
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ST_ACCESS: begin
        // Ready mode relies on the memory answering within the window
        if (rdy_en ? rdy_end : acc_done) begin // RULE3 RULE6
          state_next = ST_HOLD;
          cnt_next   = phase_len(timing_reg, `AMRS_TIM_HOLD);
        end else if (!acc_done) begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      ST_HOLD: begin
        if (acc_done) begin
          state_next = ST_IDLE; // RULE4
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = {`AMRS_FW{1'b0}};
      end
    endcase
  end

  // State, counter and ready tracker
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= {`AMRS_FW{1'b0}};
      rdy_seen_reg <= 1'b0;
      rdy_cnt_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (state_reg != ST_ACCESS) begin
        rdy_seen_reg <= 1'b0;
      end else if (!rdy_seen_reg && external_ready) begin
        rdy_seen_reg <= 1'b1; // RULE5
        rdy_cnt_reg  <= `AMRS_RDY_DELAY - 2'h1;
      end else if (rdy_seen_reg && rdy_cnt_reg != 2'h0) begin
        rdy_cnt_reg <= rdy_cnt_reg - 2'h1;
      end
    end
  end

  // Pin drive follows the next phase so every memory pin except the gated clock pin comes from a flop
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bank_select_n   <= {NB{1'b1}};
      mem_address     <= {AW{1'b0}};
      output_enable_n <= 1'b1;
      read_strobe_n   <= 1'b1;
      byte_enable_n   <= {BW{1'b1}};
    end else begin
      bank_select_n   <= (state_next == ST_IDLE) ? {NB{1'b1}} : ~bank_reg; // RULE1 RULE4
      // Launch edge takes the address from the bus, since addr_reg only lands on that same edge
      mem_address     <= start ? pwdata[AW-1:0] : ((state_next == ST_IDLE) ? mem_address : addr_reg); // RULE1
      output_enable_n <= (state_next == ST_IDLE) || (state_next == ST_PRESETUP); // RULE2 RULE4
      read_strobe_n   <= (state_next != ST_ACCESS); // RULE3
      byte_enable_n   <= (state_next == ST_IDLE) ? {BW{1'b1}} : ~be_reg; // RULE4
    end
  end

  // Register file; done is sticky, a new completion beats a clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg   <= 32'h00000000;
      timing_reg <= `AMRS_TIM_RESET;
      addr_reg   <= {AW{1'b0}};
      bank_reg   <= {NB{1'b0}};
      be_reg     <= {BW{1'b0}};
      rdata_reg  <= {DW{1'b0}};
      done_reg   <= 1'b0;
    end else begin
      if (wr_take && paddr == `AMRS_OFF_CTRL) begin
        ctrl_reg <= pwrite ? (pwdata & 32'h00000031) : ctrl_reg;
      end
      if (wr_take && paddr == `AMRS_OFF_TIMING && state_reg == ST_IDLE) begin
        timing_reg <= pwdata & 32'h3fffffff;
      end
      if (start) begin
        addr_reg <= pwdata[AW-1:0];
      end
      if (wr_take && paddr == `AMRS_OFF_SELECT && state_reg == ST_IDLE) begin
        bank_reg <= pwdata[`AMRS_SEL_BANK_LO +: NB];
        be_reg   <= pwdata[`AMRS_SEL_BE_LO +: BW];
      end
      // Data captured on the edge the strobe rises
      if (state_reg == ST_ACCESS && state_next == ST_HOLD) begin
        rdata_reg <= mem_data_in;
        done_reg  <= 1'b1;
      end else if (wr_take && paddr == `AMRS_OFF_STATUS && pwdata[`AMRS_STAT_DONE]) begin
        done_reg <= 1'b0;
      end
    end
  end

  // APB answer: one wait cycle, then pready with data
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready &
                 (paddr[7:5] != 3'h0 || paddr[4:0] > `AMRS_OFF_RDATA || paddr[1:0] != 2'h0);
      prdata  <= 32'h00000000;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          `AMRS_OFF_CTRL:   prdata <= ctrl_reg;
          `AMRS_OFF_TIMING: prdata <= timing_reg;
          `AMRS_OFF_ADDR:   prdata <= {{(32-AW){1'b0}}, addr_reg};
          `AMRS_OFF_SELECT: prdata <= {{(24-BW){1'b0}}, be_reg, {(8-NB){1'b0}}, bank_reg};
          `AMRS_OFF_STATUS: prdata <= {30'h0, done_reg, state_reg != ST_IDLE};
          `AMRS_OFF_RDATA:  prdata <= {{(32-DW){1'b0}}, rdata_reg};
          default:          prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // amrs_top
`default_nettype wire

//--- amrs_mem_model.sv
// Purpose: Memory stand-in, data from address, late ready
// Assumes: Pins synchronous to clk_sys
// Notes:   Released bus shows inverse of last word
`timescale 1ns/1ps
`default_nettype none
module amrs_mem_model (
  input  wire logic        clk_sys,
  input  wire logic [3:0]  bank_select_n,
  input  wire logic [23:0] mem_address,
  input  wire logic        output_enable_n,
  input  wire logic        read_strobe_n,
  input  wire logic [3:0]  rdy_wait,
  output var  logic [15:0] mem_data_in,
  output var  logic        external_ready
);
  logic [15:0] last_reg = 16'h0000;
  logic [3:0]  cnt_reg = 4'h0;
  // Driven only while selected and enabled, never a stale copy
  always_comb mem_data_in = (!output_enable_n && bank_select_n != 4'hf) ? mem_address[15:0] ^ 16'ha5c3 : ~last_reg;
  // Ready rises rdy_wait plus one edges into the access
  always @(posedge clk_sys) begin
    last_reg <= mem_data_in;
    cnt_reg <= read_strobe_n ? 4'h0 : cnt_reg + 4'h1;
    external_ready <= !read_strobe_n && cnt_reg >= rdy_wait;
  end
endmodule // amrs_mem_model
`default_nettype wire

//--- amrs_top_properties.sv
// Purpose: Pin timing checks of the read sequencer
// Assumes: Control word mirrored from APB writes
// Notes:   Phase counts of one give the tightest bounds
`timescale 1ns/1ps
`default_nettype none
module amrs_props #(parameter AW = 24, parameter NB = 4, parameter BW = 2) (
  input wire logic          clk_sys,
  input wire logic          rst,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic [NB-1:0] bank_select_n,
  input wire logic [AW-1:0] mem_address,
  input wire logic          output_enable_n,
  input wire logic          read_strobe_n,
  input wire logic [BW-1:0] byte_enable_n,
  input wire logic          external_ready,
  input wire logic          clock_output_pin
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [2:0] ctl_reg;
  wire        sel = bank_select_n != '1;
  // Mirror of clock select and ready enable
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) ctl_reg <= 3'h0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00) ctl_reg <= {pwdata[5:4], pwdata[0]};
  a_oe_after_bank: assert property ($fell(output_enable_n) |-> $past(sel)) else $error("oe early");
  a_bank_lead: assert property ($fell(read_strobe_n) |-> $past(sel, 3)) else $error("bank late");
  a_oe_lead: assert property ($fell(read_strobe_n) |-> $past(!output_enable_n, 2)) else $error("oe late");
  a_access_order: assert property (!read_strobe_n |-> !output_enable_n && sel) else $error("bad order");
  a_addr_steady: assert property (sel && $past(sel) |-> $stable(mem_address)) else $error("address moved");
  a_hold_pins: assert property ($rose(read_strobe_n) |-> !output_enable_n && sel && $stable(mem_address)
    && $stable(byte_enable_n)) else $error("hold broken");
  a_hold_ends: assert property ($rose(read_strobe_n) |-> ##[1:64] !sel) else $error("hold stuck");
  a_ready_end: assert property (ctl_reg[0] && !read_strobe_n && $rose(external_ready) |-> ##[3:4]
    $rose(read_strobe_n)) else $error("ready end off");
  a_clock_copy: assert property (@(negedge clk_sys) disable iff (rst)
    clock_output_pin == (ctl_reg[2:1] == 2'h3)) else $error("clock pin wrong");
  c_ready: cover property (ctl_reg[0] && $rose(read_strobe_n));
  c_err: cover property (pslverr);
  c_clk: cover property (ctl_reg[2:1] == 2'h3);
endmodule // amrs_props
bind amrs_top amrs_props #(.AW(AW), .NB(NB), .BW(BW)) u_props (.*);
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench of the read sequencer
// Assumes: APB master here, memory stand-in as partner
// Notes:   Row table for phase counts, hand tests after
`timescale 1ns/1ps
`default_nettype none
`include "amrs_map.vh"
module tb;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pb = 1, po = 1, ps = 1;
  logic pready, pslverr, output_enable_n, read_strobe_n, external_ready, clock_output_pin, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] bank_select_n, bk, rdy_wait = 4'h2;
  logic [23:0] mem_address;
  logic [1:0] byte_enable_n, bb;
  logic [15:0] mem_data_in;
  int fail_count = 0, samples_checked = 0, cyc = 0, ev[5];
  int rows[4][9] = '{'{1,1,1,1,1,1,2,1,1}, '{3,2,0,4,2,3,3,4,2}, '{0,5,2,7,0,1,7,7,1}, '{63,1,1,2,63,63,2,2,63}};
  amrs_top DUT (.*);
  amrs_mem_model mem (.*);
  initial forever #5 clk_sys = ~clk_sys;
  // Cycle of each bank and strobe edge and of the OE fall; also the hang limit
  always @(posedge clk_sys) begin
    cyc++;
    if (pb && bank_select_n != 4'hf) ev[0] = cyc;
    if (po && !output_enable_n) ev[1] = cyc;
    if (ps && !read_strobe_n) ev[2] = cyc;
    if (ps && !read_strobe_n) bk = bank_select_n;
    if (ps && !read_strobe_n) bb = byte_enable_n;
    if (!ps && read_strobe_n) ev[3] = cyc;
    if (!pb && bank_select_n == 4'hf) ev[4] = cyc;
    pb = bank_select_n == 4'hf;
    po = output_enable_n;
    ps = read_strobe_n;
    if (cyc > 30000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Launch, try a refused relaunch, wait idle, check data
  task automatic launch(input logic [23:0] a);
    apb(1, `AMRS_OFF_ADDR, {8'h00, a});
    apb(1, `AMRS_OFF_ADDR, {8'h00, ~a});
    do apb(0, `AMRS_OFF_STATUS, 0); while (rd[0] !== 1'b0);
    apb(0, `AMRS_OFF_RDATA, 0);
    chk(rd, {16'h0, a[15:0] ^ 16'ha5c3});
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    chk({read_strobe_n, output_enable_n, bank_select_n}, 6'h3f);
    rst <= 0;
    apb(0, `AMRS_OFF_TIMING, 0);
    chk(rd, `AMRS_TIM_RESET);
    apb(0, 8'h20, 0);
    chk(er, 1);
    apb(1, `AMRS_OFF_SELECT, 32'h201);
    foreach (rows[i]) begin
      apb(1, `AMRS_OFF_TIMING, {2'h0, rows[i][4][5:0], rows[i][3][5:0], rows[i][2][5:0], rows[i][1][5:0], rows[i][0][5:0]});
      launch(24'h012340 + 24'(i));
      chk(ev[1] - ev[0], rows[i][5]);
      chk(ev[2] - ev[1], rows[i][6]);
      chk(ev[3] - ev[2], rows[i][7]);
      chk(ev[4] - ev[3], rows[i][8]);
      chk(bk, 4'he);
      chk(bb, 2'h1);
    end
    apb(1, `AMRS_OFF_CTRL, 32'h31);
    @(posedge clk_sys);
    #1 chk(clock_output_pin, 1);
    apb(1, `AMRS_OFF_TIMING, 32'h01301041);
    launch(24'h00abcd);
    chk(ev[3] - ev[2], rdy_wait + 32'd4);
    apb(1, `AMRS_OFF_CTRL, 0);
    @(posedge clk_sys);
    #1 chk(clock_output_pin, 0);
    // Reset in mid read: pins idle at once, busy, done and timing back to reset
    apb(1, `AMRS_OFF_ADDR, 32'h00000055);
    repeat (4) @(posedge clk_sys);
    rst <= 1;
    repeat (3) @(posedge clk_sys);
    chk({read_strobe_n, output_enable_n, bank_select_n, byte_enable_n}, 8'hff);
    rst <= 0;
    apb(0, `AMRS_OFF_STATUS, 0);
    chk(rd, 32'h0);
    apb(0, `AMRS_OFF_TIMING, 0);
    chk(rd, `AMRS_TIM_RESET);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
